// [src/bstap_pkg.sv]
// Behaviour
// - Bypass, sample/preload and extest behave as standard
// - Enable option claims three inputs, one output
// - No test reset pin; four signals only
// - Sixteen-state controller, instruction register, data registers
// - Three boundary cells per io cell
// - Other pins give one input or output cell
// - Configuration control pins stay out of register
// - Extest capture samples every boundary cell together
// - Cells 0 and 1: test-output enable, value
// - Last cell is special update cell driving net
// - Bypass is one flop, one stage delay
// - Two user instruction decodes drive select outputs
// - User instructions route user scan-out to output
// - Data register shift clock offered to fabric
// - Idle output is NAND of clock, idle
// - Configure and readback instructions exist
// - Three-bit instruction decode table as listed
// - Io cell order: input, output, enable
package bstap_pkg;

  typedef enum logic [3:0] {
    TS_RESET  = 4'h0,
    TS_IDLE   = 4'h1,
    TS_SEL_DR = 4'h2,
    TS_CAP_DR = 4'h3,
    TS_SH_DR  = 4'h4,
    TS_EX1_DR = 4'h5,
    TS_PAU_DR = 4'h6,
    TS_EX2_DR = 4'h7,
    TS_UPD_DR = 4'h8,
    TS_SEL_IR = 4'h9,
    TS_CAP_IR = 4'ha,
    TS_SH_IR  = 4'hb,
    TS_EX1_IR = 4'hc,
    TS_PAU_IR = 4'hd,
    TS_EX2_IR = 4'he,
    TS_UPD_IR = 4'hf
  } bstap_state_t;

  typedef enum logic [2:0] {
    IN_EXTEST    = 3'h0,
    IN_SAMPLE    = 3'h1,
    IN_USER1     = 3'h2,
    IN_USER2     = 3'h3,
    IN_READBACK  = 3'h4,
    IN_CONFIGURE = 3'h5,
    IN_RESERVED  = 3'h6,
    IN_BYPASS    = 3'h7
  } bstap_instr_t;

  localparam int          BSTAP_IR_W        = 3;
  localparam logic [2:0]  BSTAP_IR_CAPTURE  = 3'h1;
  localparam int          BSTAP_CELLS_PER_IO = 3;
  localparam int          BSTAP_POS_TDO_OE  = 0;
  localparam int          BSTAP_POS_TDO_VAL = 1;
  localparam int          BSTAP_POS_FIRST_IO = 2;
  localparam int          BSTAP_OFS_IN      = 0;
  localparam int          BSTAP_OFS_OUT     = 1;
  localparam int          BSTAP_OFS_OE      = 2;
  localparam int          BSTAP_SPECIAL_CELLS = 3;

endpackage : bstap_pkg

// [src/bstap_tap.sv]
`timescale 1ns/1ns
`default_nettype none
module bstap_tap
  import bstap_pkg::*;
#(
  parameter int N_IO  = 8,                  // Bidirectional io cells
  parameter int N_IN  = 2,                  // Input-only pins
  parameter int N_OUT = 1                   // Output-only pins
) (
  input  wire logic             clk,                // 20 MHz system clock
  input  wire logic             rst,                // Sync reset, active high
  input  wire logic             scan_enable,        // Test option enabled
  input  wire logic             tck,                // Test clock pin
  input  wire logic             tms,                // Mode select pin
  input  wire logic             tdi,                // Serial data in pin
  output logic                  tdo,                // Serial data out pin
  output logic                  tdo_oe,             // High while driving tdo
  input  wire logic [N_IO-1:0]  io_pin_in,          // Io cell pad levels
  input  wire logic [N_IO-1:0]  io_core_out,        // Fabric output values
  input  wire logic [N_IO-1:0]  io_core_oe,         // Fabric output enables
  output logic      [N_IO-1:0]  io_pin_out,         // Io cell pad drive value
  output logic      [N_IO-1:0]  io_pin_oe,          // Io cell pad drive enable
  input  wire logic [N_IN-1:0]  in_pin,             // Input-only pad levels
  input  wire logic [N_OUT-1:0] out_core,           // Fabric values for out pins
  output logic      [N_OUT-1:0] out_pin,            // Output-only pad values
  input  wire logic             tdo_t_capture,      // Internal net into cell 0
  input  wire logic             tdo_o_capture,      // Internal net into cell 1
  output logic                  special_update_cell,// Last cell update value
  output logic                  user_one_select,    // User one decode
  output logic                  user_two_select,    // User two decode
  input  wire logic             user_one_scan_out,  // Fabric serial data, user one
  input  wire logic             user_two_scan_out,  // Fabric serial data, user two
  output logic                  user_shift_clock,   // Data register clock to fabric
  output logic                  user_idle_gate,     // NAND of tck and idle
  output logic                  config_select,      // Configure instruction active
  output logic                  readback_select,    // Readback instruction active
  output logic                  config_shift,       // Shift-DR rising edge strobe
  output logic                  config_data,        // Sampled tdi for configuration
  input  wire logic             config_dout,        // Configuration chain output
  input  wire logic             readback_data       // Readback serial data
);

  // Configuration restart, clock and done pins have no cells here
  localparam int L = BSTAP_SPECIAL_CELLS + BSTAP_CELLS_PER_IO * N_IO + N_IN + N_OUT;
  localparam int POS_IN_ONLY  = BSTAP_POS_FIRST_IO + BSTAP_CELLS_PER_IO * N_IO;
  localparam int POS_OUT_ONLY = POS_IN_ONLY + N_IN;
  localparam int POS_LAST     = L - 1;

  // All state in one record, registered in one place
  typedef struct packed {
    logic                tck_s1;
    logic                tck_s2;
    logic                tck_s3;
    logic                tms_s1;
    logic                tms_s2;
    logic                tdi_s1;
    logic                tdi_s2;
    logic [N_IO-1:0]     io_s1;
    logic [N_IO-1:0]     io_s2;
    logic [N_IN-1:0]     in_s1;
    logic [N_IN-1:0]     in_s2;
    bstap_state_t        state;
    logic [BSTAP_IR_W-1:0] ir_sh;
    bstap_instr_t        ir;
    logic                bypass;
    logic [L-1:0]        bsr;
    logic [L-1:0]        upd;
    logic                tdo;
    logic                tdo_oe;
    logic [N_IO-1:0]     pin_out;
    logic [N_IO-1:0]     pin_oe;
    logic [N_OUT-1:0]    out_pin;
    logic                shift_clk;
    logic                idle_gate;
    logic                cfg_shift;
    logic                cfg_data;
  } bstap_regs_t;

  bstap_regs_t s_r;
  bstap_regs_t s_nxt;

  // Standard controller graph; m is the synchronised mode bit
  function automatic bstap_state_t tap_next(input bstap_state_t st, input logic m);
    bstap_state_t r;
    r = st;
    unique case (st)
      TS_RESET: begin
        r = m ? TS_RESET  : TS_IDLE;
      end
      TS_IDLE: begin
        r = m ? TS_SEL_DR : TS_IDLE;
      end
      TS_SEL_DR: begin
        r = m ? TS_SEL_IR : TS_CAP_DR;
      end
      TS_CAP_DR: begin
        r = m ? TS_EX1_DR : TS_SH_DR;
      end
      TS_SH_DR: begin
        r = m ? TS_EX1_DR : TS_SH_DR;
      end
      TS_EX1_DR: begin
        r = m ? TS_UPD_DR : TS_PAU_DR;
      end
      TS_PAU_DR: begin
        r = m ? TS_EX2_DR : TS_PAU_DR;
      end
      TS_EX2_DR: begin
        r = m ? TS_UPD_DR : TS_SH_DR;
      end
      TS_UPD_DR: begin
        r = m ? TS_SEL_DR : TS_IDLE;
      end
      TS_SEL_IR: begin
        r = m ? TS_RESET  : TS_CAP_IR;
      end
      TS_CAP_IR: begin
        r = m ? TS_EX1_IR : TS_SH_IR;
      end
      TS_SH_IR: begin
        r = m ? TS_EX1_IR : TS_SH_IR;
      end
      TS_EX1_IR: begin
        r = m ? TS_UPD_IR : TS_PAU_IR;
      end
      TS_PAU_IR: begin
        r = m ? TS_EX2_IR : TS_PAU_IR;
      end
      TS_EX2_IR: begin
        r = m ? TS_UPD_IR : TS_SH_IR;
      end
      TS_UPD_IR: begin
        r = m ? TS_SEL_DR : TS_IDLE;
      end
    endcase
    return r;
  endfunction : tap_next

  // Bit index of one cell inside an io cell group
  function automatic int cell_pos(input int k, input int ofs);
    return BSTAP_POS_FIRST_IO + BSTAP_CELLS_PER_IO * k + ofs;
  endfunction : cell_pos

  // Serial output source for the data side, chosen by the held instruction
  function automatic logic tdo_source(input bstap_instr_t ins, input logic bsr0,
                                      input logic byp, input logic u1, input logic u2,
                                      input logic rb, input logic cfg);
    logic v;
    v = byp;
    unique case (ins)
      IN_EXTEST,
      IN_SAMPLE:    v = bsr0;
      IN_USER1:     v = u1;
      IN_USER2:     v = u2;
      IN_READBACK:  v = rb;
      IN_CONFIGURE: v = cfg;
      // Reserved code falls back to bypass so the chain stays intact
      IN_RESERVED,
      IN_BYPASS:    v = byp;
    endcase
    return v;
  endfunction : tdo_source

  logic tck_rise;
  logic tck_fall;
  logic user_dr;
  logic bsr_instr;
  logic extest;
  logic in_cap_dr;
  logic in_sh_dr;
  logic in_sh_ir;
  logic in_idle;

  // Edge strobes last one clk each
  always_comb begin
    in_cap_dr = (s_r.state == TS_CAP_DR);
    in_sh_dr  = (s_r.state == TS_SH_DR);
    in_sh_ir  = (s_r.state == TS_SH_IR);
    in_idle   = (s_r.state == TS_IDLE);
    tck_rise  = s_r.tck_s2 & ~s_r.tck_s3;
    tck_fall  = ~s_r.tck_s2 & s_r.tck_s3;
    user_dr   = (s_r.ir == IN_USER1) || (s_r.ir == IN_USER2);
    bsr_instr = (s_r.ir == IN_EXTEST) || (s_r.ir == IN_SAMPLE);
    extest    = (s_r.ir == IN_EXTEST);
  end

  always_comb begin
    s_nxt = s_r;
    // Pins are asynchronous to clk; two stages before use
    s_nxt.tck_s1 = tck;
    s_nxt.tck_s2 = s_r.tck_s1;
    // Third tck stage only feeds the edge detector
    s_nxt.tck_s3 = s_r.tck_s2;
    s_nxt.tms_s1 = tms;
    s_nxt.tms_s2 = s_r.tms_s1;
    s_nxt.tdi_s1 = tdi;
    s_nxt.tdi_s2 = s_r.tdi_s1;
    s_nxt.io_s1  = io_pin_in;
    s_nxt.io_s2  = s_r.io_s1;
    s_nxt.in_s1  = in_pin;
    s_nxt.in_s2  = s_r.in_s1;
    s_nxt.cfg_shift = 1'b0;

    if (!scan_enable) begin
      // Option off: controller parked, output pin released
      s_nxt.state  = TS_RESET;
      s_nxt.ir     = IN_BYPASS;
      s_nxt.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      // Controller advances on rising test clock only
      s_nxt.state = tap_next(s_r.state, s_r.tms_s2);
      unique case (s_r.state)
        TS_RESET: begin
          // Reset state reloads bypass; reached by five tms-high clocks, by rst or with the option off
          s_nxt.ir = IN_BYPASS;
        end
        TS_CAP_IR: begin
          s_nxt.ir_sh = BSTAP_IR_CAPTURE;
        end
        TS_SH_IR: begin
          s_nxt.ir_sh = {s_r.tdi_s2, s_r.ir_sh[BSTAP_IR_W-1:1]};
        end
        TS_UPD_IR: begin
          // Reserved code is kept and served as bypass
          s_nxt.ir = bstap_instr_t'(s_r.ir_sh);
        end
        TS_CAP_DR: begin
          // Bypass captures zero so a chain can be counted
          s_nxt.bypass = 1'b0;
          if (bsr_instr) begin
            // All cells sampled in the same clock
            s_nxt.bsr[BSTAP_POS_TDO_OE]  = tdo_t_capture;
            s_nxt.bsr[BSTAP_POS_TDO_VAL] = tdo_o_capture;
            for (int k = 0; k < N_IO; k++) begin
              // Input, output, enable within each io cell
              s_nxt.bsr[cell_pos(k, BSTAP_OFS_IN)]  = s_r.io_s2[k];
              s_nxt.bsr[cell_pos(k, BSTAP_OFS_OUT)] = s_r.pin_out[k];
              s_nxt.bsr[cell_pos(k, BSTAP_OFS_OE)]  = s_r.pin_oe[k];
            end
            for (int k = 0; k < N_IN; k++) begin
              s_nxt.bsr[POS_IN_ONLY + k] = s_r.in_s2[k];
            end
            for (int k = 0; k < N_OUT; k++) begin
              s_nxt.bsr[POS_OUT_ONLY + k] = s_r.out_pin[k];
            end
            s_nxt.bsr[POS_LAST] = s_r.upd[POS_LAST];
          end
        end
        TS_SH_DR: begin
          s_nxt.bypass = s_r.tdi_s2;
          if (bsr_instr) begin
            s_nxt.bsr = {s_r.tdi_s2, s_r.bsr[L-1:1]};
          end
          if (s_r.ir == IN_CONFIGURE) begin
            // One-clk strobe; configuration logic takes config_data with it
            s_nxt.cfg_shift = 1'b1;
            s_nxt.cfg_data  = s_r.tdi_s2;
          end
        end
        TS_UPD_DR: begin
          // Preload under sample, drive under extest
          // Update stage moves only here, so pads hold while shifting
          if (bsr_instr) begin
            s_nxt.upd = s_r.bsr;
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      // Output changes on falling test clock
      s_nxt.tdo_oe = in_sh_dr || in_sh_ir;
      if (in_sh_ir) begin
        // Shift-IR shows the instruction shifter
        s_nxt.tdo = s_r.ir_sh[0];
      end else begin
        s_nxt.tdo = tdo_source(s_r.ir, s_r.bsr[0], s_r.bypass, user_one_scan_out,
                               user_two_scan_out, readback_data, config_dout);
      end
    end

    // Pad drive; one clk of latency traded for registered outputs
    for (int k = 0; k < N_IO; k++) begin
      if (extest) begin
        s_nxt.pin_out[k] = s_r.upd[cell_pos(k, BSTAP_OFS_OUT)];
        s_nxt.pin_oe[k]  = s_r.upd[cell_pos(k, BSTAP_OFS_OE)];
      end else begin
        s_nxt.pin_out[k] = io_core_out[k];
        // Configuration owns the pads; fabric may not drive them
        s_nxt.pin_oe[k]  = io_core_oe[k] && (s_r.ir != IN_CONFIGURE);
      end
    end
    for (int k = 0; k < N_OUT; k++) begin
      if (extest) begin
        s_nxt.out_pin[k] = s_r.upd[POS_OUT_ONLY + k];
      end else begin
        s_nxt.out_pin[k] = out_core[k];
      end
    end

    // Clock follows tck only in user capture/shift; parked high otherwise
    if (user_dr && (in_cap_dr || in_sh_dr)) begin
      s_nxt.shift_clk = s_r.tck_s2;
    end else begin
      s_nxt.shift_clk = 1'b1;
    end
    s_nxt.idle_gate = ~(s_r.tck_s2 & in_idle);

    // Synchroniser stages clear to the idle tck level, so no false edge
    if (rst) begin
      s_nxt = '0;
      s_nxt.state     = TS_RESET;
      s_nxt.ir        = IN_BYPASS;
      s_nxt.ir_sh     = BSTAP_IR_CAPTURE;
      s_nxt.shift_clk = 1'b1;
      s_nxt.idle_gate = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Selects decode straight from the held instruction
  always_comb begin
    tdo                 = s_r.tdo;
    tdo_oe              = s_r.tdo_oe;
    io_pin_out          = s_r.pin_out;
    io_pin_oe           = s_r.pin_oe;
    out_pin             = s_r.out_pin;
    special_update_cell = s_r.upd[POS_LAST];
    user_one_select     = (s_r.ir == IN_USER1);
    user_two_select     = (s_r.ir == IN_USER2);
    user_shift_clock    = s_r.shift_clk;
    user_idle_gate      = s_r.idle_gate;
    config_select       = (s_r.ir == IN_CONFIGURE);
    readback_select     = (s_r.ir == IN_READBACK);
    config_shift        = s_r.cfg_shift;
    config_data         = s_r.cfg_data;
  end

endmodule : bstap_tap
`default_nettype wire

// [tb/bstap_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module bstap_checker #(
  parameter int N_IO = 8  // Io cells
) (
  input wire logic            clk,              // System clock
  input wire logic            rst,              // Sync reset
  input wire logic            scan_enable,      // Test option
  input wire logic            tck,              // Test clock pin
  input wire logic            tdo,              // Serial out
  input wire logic            tdo_oe,           // Serial out enable
  input wire logic [N_IO-1:0] io_core_out,      // Fabric values
  input wire logic [N_IO-1:0] io_core_oe,       // Fabric enables
  input wire logic [N_IO-1:0] io_pin_out,       // Pad values
  input wire logic [N_IO-1:0] io_pin_oe,        // Pad enables
  input wire logic            user_one_select,  // User one
  input wire logic            user_two_select,  // User two
  input wire logic            user_shift_clock, // Fabric clock
  input wire logic            user_idle_gate,   // Idle gate
  input wire logic            config_select,    // Configure
  input wire logic            readback_select,  // Readback
  input wire logic            config_shift      // Config strobe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_tck_still;
    !tck [*4];
  endsequence
  sequence s_strobe;
    config_select ##1 !config_shift;
  endsequence
  a_park_oe_off: assert property (!scan_enable [*3] |-> !tdo_oe)
    else $error("tdo enabled with test option off");
  a_sel_onehot: assert property (
    $onehot0({user_one_select, user_two_select, config_select, readback_select}))
    else $error("two decodes active");
  // Pin falls are seen 3 to 4 clocks late, so look back two samples
  a_tdo_after_fall: assert property (disable iff (rst || !scan_enable)
    $changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved in high phase");
  a_oe_after_fall: assert property (disable iff (rst || !scan_enable)
    $changed(tdo_oe) |-> !$past(tck, 2)) else $error("tdo_oe moved in high phase");
  a_shift_clk_rest: assert property (
    !user_one_select && !user_two_select |-> user_shift_clock)
    else $error("shift clock active without user decode");
  a_idle_gate_rest: assert property (s_tck_still |-> user_idle_gate)
    else $error("idle gate low with tck low");
  a_idle_gate_fall: assert property (
    $fell(user_idle_gate) |-> $past(tck, 3) || $past(tck, 4))
    else $error("idle gate fell without tck high");
  a_cfg_strobe_pulse: assert property (config_shift |-> s_strobe)
    else $error("config strobe not a single pulse");
  a_pads_follow_core: assert property (
    $past(user_one_select || user_two_select || readback_select) |->
    io_pin_out == $past(io_core_out) && io_pin_oe == $past(io_core_oe))
    else $error("pads not from fabric");
  a_cfg_oe_off: assert property ($past(config_select) |-> io_pin_oe == '0)
    else $error("pad enabled under configure");
endmodule : bstap_checker
`default_nettype wire

// [tb/bstap_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bstap_ctrl_model (
  output logic      tck,   // Test clock, still between frames
  output logic      tms,   // Mode select
  output logic      tdi,   // Serial data to device
  input  wire logic tdo,   // Serial data from device
  input  wire logic tdo_oe // Device drives tdo
);
  logic q_last = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Undriven tdo reads as the inverse of the last bit, never a lucky match
  task tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #200 q = tdo_oe ? tdo : ~q_last;
    q_last = q;
    tck = 1'b1;
    #200 tck = 1'b0;
  endtask : tick
  task reset_tap;
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask : reset_tap
  // From idle: shift n bits LSB first, then update and back to idle
  task scan(input logic ir, input logic [63:0] d, input int n, output logic [63:0] o);
    logic q;
    o = '0;
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], q);
      o[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask : scan
endmodule : bstap_ctrl_model
`default_nettype wire

// [tb/boundary_scan_tap_logic_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_tap_logic_tb_top;
  import bstap_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, scan_enable = 1'b1, tck, tms, tdi, tdo, tdo_oe;
  logic [7:0]  io_pin_in, io_core_out, io_core_oe, io_pin_out, io_pin_oe;
  logic [1:0]  in_pin;
  logic        out_core, out_pin, tdo_t_capture, tdo_o_capture, special_update_cell;
  logic        user_one_select, user_two_select, user_one_scan_out, user_two_scan_out;
  logic        user_shift_clock, user_idle_gate, config_select, readback_select;
  logic        config_shift, config_data, config_dout, readback_data;
  logic [63:0] dout, pre, expv;
  logic [31:0] r;
  int          num_errors = 0, comparisons = 0, seed = 32'ha23d2387;
  bstap_tap uut (.clk, .rst, .scan_enable, .tck, .tms, .tdi, .tdo, .tdo_oe, .io_pin_in,
    .io_core_out, .io_core_oe, .io_pin_out, .io_pin_oe, .in_pin, .out_core, .out_pin,
    .tdo_t_capture, .tdo_o_capture, .special_update_cell, .user_one_select,
    .user_two_select, .user_one_scan_out, .user_two_scan_out, .user_shift_clock,
    .user_idle_gate, .config_select, .readback_select, .config_shift, .config_data,
    .config_dout, .readback_data);
  bstap_ctrl_model ctl (.tck, .tms, .tdi, .tdo, .tdo_oe);
  always #25 clk = ~clk;
  task check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task rnd;
    @(posedge clk);
    #2 r = $random(seed);
    {io_pin_in, io_core_out, io_core_oe, in_pin, out_core, tdo_t_capture, tdo_o_capture} = r[28:0];
    r = $random(seed);
  endtask : rnd
  function automatic logic [63:0] sel_exp(input int c);
    return (c >= 2 && c <= 5) ? 64'h8 >> (c - 2) : 64'h0;
  endfunction : sel_exp
  // Fabric sources are held for the scan, so every bit repeats them
  function automatic logic [63:0] dr_exp(input int c, input logic [63:0] d);
    case (c)
      2: return {59'h0, {5{d[31]}}};
      3: return {59'h0, {5{d[30]}}};
      4: return {59'h0, {5{d[29]}}};
      5: return {59'h0, {5{d[28]}}};
      default: return {59'h0, d[3:0], 1'b0};
    endcase
  endfunction : dr_exp
  function automatic logic [63:0] cap_exp(input logic ext, input logic [63:0] p);
    logic [63:0] v;
    v = '0;
    v[1:0] = {tdo_o_capture, tdo_t_capture};
    for (int k = 0; k < 8; k++) begin
      v[2+3*k] = io_pin_in[k];
      v[3+3*k] = ext ? p[3+3*k] : io_core_out[k];
      v[4+3*k] = ext ? p[4+3*k] : io_core_oe[k];
    end
    v[27:26] = in_pin;
    v[28] = ext ? p[28] : out_core;
    v[29] = special_update_cell;
    return v;
  endfunction : cap_exp
  initial begin
    {io_pin_in, io_core_out, io_core_oe, in_pin, out_core, tdo_t_capture, tdo_o_capture} = '0;
    {user_one_scan_out, user_two_scan_out, readback_data, config_dout} = 4'ha;
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    rnd();
    ctl.reset_tap();
    ctl.scan(1'b1, 64'h7, 3, dout);
    check(dout, 64'(BSTAP_IR_CAPTURE));
    for (int c = 0; c < 8; c++) begin
      rnd();
      {user_one_scan_out, user_two_scan_out, readback_data, config_dout} = r[31:28];
      ctl.scan(1'b1, 64'(c), 3, dout);
      check(64'({user_one_select, user_two_select, readback_select, config_select}), sel_exp(c));
      if (c > 1) begin
        ctl.scan(1'b0, 64'(r), 5, dout);
        check(dout, dr_exp(c, 64'(r)));
        if (c == 5) check(64'(config_data), 64'(r[4]));
      end
    end
    ctl.scan(1'b1, 64'(IN_SAMPLE), 3, dout);
    rnd();
    pre = {34'h0, r[29:0]};
    expv = cap_exp(1'b0, pre);
    ctl.scan(1'b0, pre, 30, dout);
    check(dout, expv);
    check(64'(special_update_cell), 64'(pre[29]));
    ctl.scan(1'b1, 64'(IN_EXTEST), 3, dout);
    for (int k = 0; k < 8; k++) check(64'({io_pin_oe[k], io_pin_out[k]}), 64'(pre[4+3*k-:2]));
    check(64'(out_pin), 64'(pre[28]));
    rnd();
    expv = cap_exp(1'b1, pre);
    ctl.scan(1'b0, {34'h0, r[29:0]}, 30, dout);
    check(dout, expv);
    scan_enable = 1'b0;
    repeat (4) @(posedge clk);
    #2 check(64'({tdo_oe, user_one_select, user_two_select, config_select}), 64'h0);
    check(64'(io_pin_out), 64'(io_core_out));
    end_sim();
  end
  // Whole run needs about a tenth of a millisecond
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
endmodule : boundary_scan_tap_logic_tb_top
bind bstap_tap bstap_checker #(.N_IO(N_IO)) chk (.clk, .rst, .scan_enable, .tck, .tdo,
  .tdo_oe, .io_core_out, .io_core_oe, .io_pin_out, .io_pin_oe, .user_one_select,
  .user_two_select, .user_shift_clock, .user_idle_gate, .config_select, .readback_select,
  .config_shift);
`default_nettype wire
